// ---- tpm_defines.svh ----
`ifndef TPM_DEFINES_SVH
`define TPM_DEFINES_SVH

// Register byte offsets
`define TPM_OFS_MODE     8'h00
`define TPM_OFS_CAPCTRL  8'h04
`define TPM_OFS_OUTCTRL  8'h08
`define TPM_OFS_PRESCALE 8'h0C
`define TPM_OFS_COUNT    8'h10
`define TPM_OFS_PERIOD   8'h14
`define TPM_OFS_WIDTH    8'h18

// Mode control fields
`define TPM_MODE_OVF     0
`define TPM_MODE_LO      2
`define TPM_MODE_HI      3

// Capture/compare control fields
`define TPM_CC_PER_CAP   0
`define TPM_CC_PER_OPP   1
`define TPM_CC_WID_CAP   2

// Output control fields
`define TPM_OC_OE        0
`define TPM_OC_INV_PER   1
`define TPM_OC_INV_WID   4
`define TPM_OC_OS_EN     5
`define TPM_OC_OS_TRIG   6

// Prescaler and edge select fields
`define TPM_PR_CLK_LO    0
`define TPM_PR_PRI_LO    4
`define TPM_PR_SEC_LO    6

// Edge select codes
`define TPM_EDGE_FALL    2'h0
`define TPM_EDGE_RISE    2'h1
`define TPM_EDGE_NONE    2'h2
`define TPM_EDGE_BOTH    2'h3

`define TPM_CNT_MAX      16'hFFFF

`endif

// ---- tpm_pkg.sv ----
`default_nettype none
package tpm_pkg;

	typedef enum logic [1:0] {
		TPM_STOP,
		TPM_FREE,
		TPM_EDGE_CLR,
		TPM_MATCH_CLR
	} tpm_mode_t;

	typedef struct packed {
		logic valid;
		logic opposite;
	} tpm_edge_t;

	typedef struct packed {
		logic [15:0] cnt;
		logic [15:0] per;
		logic [15:0] wid;
		tpm_mode_t   mode;
		logic        ovf;
		logic [2:0]  crc;
		logic        oe;
		logic        inv_per;
		logic        inv_wid;
		logic        os_en;
		logic [7:0]  prm;
		logic        os_armed;
		logic        level;
		logic        pin;
		logic [31:0] rdata;
		logic        err;
		logic        per_irq;
		logic        wid_irq;
	} tpm_state_t;

endpackage
`default_nettype wire

// ---- tpm_edge_detect.sv ----
`default_nettype none
module tpm_edge_detect
	import tpm_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       pin_in,
	input  wire logic [1:0] sel,
	output tpm_edge_t       edge_out
);
	`include "tpm_defines.svh"

	logic [2:0] sh;
	logic       rise;
	logic       fall;

	assign rise = sh[1] & ~sh[2];
	assign fall = ~sh[1] & sh[2];

	// Two-stage synchroniser, then one stage of history
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sh       <= 3'h0;
			edge_out <= '0;
		end else begin
			sh             <= {sh[1:0], pin_in};
			edge_out.valid <= (sel == `TPM_EDGE_RISE && rise) || (sel == `TPM_EDGE_FALL && fall)
				|| (sel == `TPM_EDGE_BOTH && (rise || fall));
			edge_out.opposite <= (sel == `TPM_EDGE_RISE && fall)
				|| (sel == `TPM_EDGE_FALL && rise);
		end
	end
endmodule // tpm_edge_detect
`default_nettype wire

// ---- tpm_prescaler.sv ----
`default_nettype none
module tpm_prescaler #(
	parameter int DIV_W = 4
) (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       run,
	input  wire logic [1:0] sel,
	output logic            tick
);
	logic [DIV_W-1:0] div;

	// Divide by 1, 2, 4 or 2**DIV_W
	function automatic logic [DIV_W-1:0] div_mask(input logic [1:0] s);
		case (s)
			2'h0:    div_mask = '0;
			2'h1:    div_mask = DIV_W'(1);
			2'h2:    div_mask = DIV_W'(3);
			default: div_mask = '1;
		endcase
	endfunction

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div  <= '0;
			tick <= 1'b0;
		end else begin
			div  <= run ? div + DIV_W'(1) : '0;
			tick <= run && ((div & div_mask(sel)) == div_mask(sel));
		end
	end
endmodule // tpm_prescaler
`default_nettype wire

// ---- tpm_timer.sv ----
// The placing of the registers and the APB slave port were decided locally.
`default_nettype none
module tpm_timer
	import tpm_pkg::*;
#(
	parameter int DIV_W = 4
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        primary_in_pin,
	input  wire logic        secondary_in_pin,
	output logic             timer_out_pin,
	output logic             period_irq,
	output logic             width_irq
);
	`include "tpm_defines.svh"

	tpm_state_t s;
	tpm_state_t next_s;
	tpm_edge_t  pe;
	tpm_edge_t  se;
	logic       tick;
	logic       running;
	logic       wr;
	logic       per_cap;
	logic       wid_cap;
	logic       pm;
	logic       wm;
	logic       os_mode;
	logic       trig;
	logic       edge_clr;
	logic       per_src;

	tpm_prescaler #(
		.DIV_W (DIV_W)
	) u_prescaler (
		.pclk    (pclk),
		.presetn (presetn),
		.run     (running),
		.sel     (s.prm[`TPM_PR_CLK_LO +: 2]),
		.tick    (tick)
	);

	tpm_edge_detect u_primary (
		.pclk     (pclk),
		.presetn  (presetn),
		.pin_in   (primary_in_pin),
		.sel      (s.prm[`TPM_PR_PRI_LO +: 2]),
		.edge_out (pe)
	);

	tpm_edge_detect u_secondary (
		.pclk     (pclk),
		.presetn  (presetn),
		.pin_in   (secondary_in_pin),
		.sel      (s.prm[`TPM_PR_SEC_LO +: 2]),
		.edge_out (se)
	);

	function automatic logic [31:0] read_mux(input logic [7:0] a, input tpm_state_t st);
		read_mux = 32'h0;
		if (a == `TPM_OFS_MODE) begin
			read_mux[`TPM_MODE_HI:`TPM_MODE_LO] = st.mode;
			read_mux[`TPM_MODE_OVF]              = st.ovf;
		end else if (a == `TPM_OFS_CAPCTRL) begin
			read_mux[2:0] = st.crc;
		end else if (a == `TPM_OFS_OUTCTRL) begin
			read_mux[`TPM_OC_OE]      = st.oe;
			read_mux[`TPM_OC_INV_PER] = st.inv_per;
			read_mux[`TPM_OC_INV_WID] = st.inv_wid;
			read_mux[`TPM_OC_OS_EN]   = st.os_en;
		end else if (a == `TPM_OFS_PRESCALE) begin
			read_mux[7:0] = st.prm;
		end else if (a == `TPM_OFS_COUNT) begin
			read_mux[15:0] = st.cnt;
		end else if (a == `TPM_OFS_PERIOD) begin
			read_mux[15:0] = st.per;
		end else if (a == `TPM_OFS_WIDTH) begin
			read_mux[15:0] = st.wid;
		end
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == `TPM_OFS_MODE) || (a == `TPM_OFS_CAPCTRL) || (a == `TPM_OFS_OUTCTRL)
			|| (a == `TPM_OFS_PRESCALE) || (a == `TPM_OFS_COUNT)
			|| (a == `TPM_OFS_PERIOD) || (a == `TPM_OFS_WIDTH);
	endfunction

	assign running  = s.mode != TPM_STOP;
	assign wr       = psel && penable && pwrite && mapped(paddr);
	assign per_cap  = s.crc[`TPM_CC_PER_CAP];
	assign wid_cap  = s.crc[`TPM_CC_WID_CAP];
	assign per_src  = s.crc[`TPM_CC_PER_OPP] ? pe.opposite : se.valid;
	assign pm       = running && tick && !per_cap && s.cnt == s.per;
	assign wm       = running && tick && !wid_cap && s.cnt == s.wid;
	assign os_mode  = s.os_en && (s.mode == TPM_FREE || s.mode == TPM_EDGE_CLR);
	assign trig     = os_mode && ((wr && paddr == `TPM_OFS_OUTCTRL && pwdata[`TPM_OC_OS_TRIG])
		|| pe.valid);
	assign edge_clr = s.mode == TPM_EDGE_CLR && pe.valid;

	always_comb begin
		next_s         = s;
		next_s.per_irq = 1'b0;
		next_s.wid_irq = 1'b0;
		next_s.err     = 1'b0;
		// Bus writes first, so hardware events below win over them
		if (wr) begin
			if (paddr == `TPM_OFS_MODE) begin
				next_s.mode = tpm_mode_t'(pwdata[`TPM_MODE_HI:`TPM_MODE_LO]);
				next_s.ovf  = pwdata[`TPM_MODE_OVF];
			end else if (paddr == `TPM_OFS_CAPCTRL) begin
				next_s.crc = pwdata[2:0];
			end else if (paddr == `TPM_OFS_OUTCTRL) begin
				next_s.oe      = pwdata[`TPM_OC_OE];
				next_s.inv_per = pwdata[`TPM_OC_INV_PER];
				next_s.inv_wid = pwdata[`TPM_OC_INV_WID];
				next_s.os_en   = pwdata[`TPM_OC_OS_EN];
			end else if (paddr == `TPM_OFS_PRESCALE) begin
				next_s.prm = pwdata[7:0];
			end else if (paddr == `TPM_OFS_PERIOD) begin
				next_s.per = pwdata[15:0];
			end else if (paddr == `TPM_OFS_WIDTH) begin
				next_s.wid = pwdata[15:0];
			end
		end
		// Read data latched in the setup cycle, answered in the access cycle
		if (psel && !penable) begin
			next_s.rdata = pwrite ? 32'h0 : read_mux(paddr, s);
			next_s.err   = !mapped(paddr);
		end else begin
			next_s.err = s.err && psel && penable ? 1'b0 : s.err;
		end
		// Captures use the count before any clear of this cycle
		if (per_cap && running && per_src) begin
			next_s.per = s.cnt;
		end
		if (wid_cap && running && pe.valid) begin
			next_s.wid = s.cnt;
		end
		// Counter
		if (!running) begin
			next_s.cnt = 16'h0;
		end else if (trig || edge_clr) begin
			next_s.cnt = 16'h0;
		end else if (tick) begin
			if (s.mode == TPM_MATCH_CLR && pm) begin
				next_s.cnt = 16'h0;
			end else begin
				next_s.cnt = s.cnt + 16'h1;
				if (s.cnt == `TPM_CNT_MAX) begin
					next_s.ovf = 1'b1;
				end
			end
		end
		// Events
		next_s.per_irq = pm || (per_cap && running && se.valid && !s.crc[`TPM_CC_PER_OPP]);
		next_s.wid_irq = wm || (wid_cap && running && pe.valid);
		// Output level
		if (os_mode) begin
			if (trig) begin
				next_s.os_armed = 1'b1;
			end else if (s.os_armed && wm) begin
				next_s.os_armed = 1'b0;
			end
			if (s.os_armed && !trig && (pm || wm)) begin
				next_s.level = !s.level;
			end
		end else begin
			next_s.os_armed = 1'b0;
			if ((pm && s.inv_per) ^ (wm && s.inv_wid)) begin
				next_s.level = !s.level;
			end
		end
		next_s.pin = next_s.level && next_s.oe;
		if (psel && penable) begin
			next_s.err = s.err;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign prdata        = s.rdata;
	assign pready        = 1'b1;
	assign pslverr       = psel && penable && s.err;
	assign timer_out_pin = s.pin;
	assign period_irq    = s.per_irq;
	assign width_irq     = s.wid_irq;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	chk_period_clear: assert property (
		(s.mode == TPM_MATCH_CLR && pm && !wr) |=> (s.cnt == 16'h0 && period_irq))
		else $error("period match did not clear counter");

	chk_width_noclear: assert property (
		(s.mode == TPM_MATCH_CLR && wm && !pm && !wr) |=> (s.cnt == $past(s.cnt) + 16'h1 && width_irq))
		else $error("width match disturbed counter");

	chk_wrap_ovf: assert property (
		(tick && s.cnt == `TPM_CNT_MAX && running && !pm && !trig && !edge_clr && !wr)
		|=> (s.cnt == 16'h0 && s.ovf))
		else $error("counter wrap did not set overflow");

	chk_trig_clear: assert property (
		(trig && !wr) |=> (s.cnt == 16'h0 && s.os_armed))
		else $error("one-shot trigger did not restart counter");

	chk_oneshot_flip: assert property (
		(os_mode && s.os_armed && pm && !trig && !wr) |=> (s.level != $past(s.level) && period_irq))
		else $error("one-shot period match did not invert output");

	chk_oneshot_end: assert property (
		(os_mode && s.os_armed && wm && !pm && !trig && !wr) |=> (!s.os_armed && width_irq))
		else $error("one-shot width match did not end pulse");

	chk_width_capture: assert property (
		(wid_cap && running && pe.valid && !wr) |=> (s.wid == $past(s.cnt) && width_irq))
		else $error("primary edge did not capture width");

	chk_period_capture: assert property (
		(per_cap && running && per_src && !wr) |=> s.per == $past(s.cnt))
		else $error("period capture lost");

	chk_opposite_quiet: assert property (
		(per_cap && s.crc[`TPM_CC_PER_OPP] && !pm) |=> !period_irq)
		else $error("opposite edge raised period event");

	chk_edge_restart: assert property (
		(edge_clr && !wr) |=> s.cnt == 16'h0)
		else $error("edge mode did not clear counter");

	chk_ppg_toggle: assert property (
		(!os_mode && running && pm && s.inv_per && !(wm && s.inv_wid) && !wr)
		|=> s.level != $past(s.level))
		else $error("pulse generation did not invert output");

	chk_stop_hold: assert property (
		!running |=> s.cnt == 16'h0)
		else $error("stopped counter not held at zero");

	chk_stop_quiet: assert property (
		!running |=> (!period_irq && !width_irq))
		else $error("stopped timer raised an event");

	chk_count_step: assert property (
		(running && tick && s.mode != TPM_MATCH_CLR && !trig && !edge_clr)
		|=> s.cnt == $past(s.cnt) + 16'h1)
		else $error("counter did not advance on tick");

	chk_count_hold: assert property (
		(running && !tick && !trig && !edge_clr) |=> $stable(s.cnt))
		else $error("counter moved without a tick");

	chk_read_count: assert property (
		(psel && !penable && !pwrite && paddr == `TPM_OFS_COUNT)
		|=> prdata[15:0] == $past(s.cnt))
		else $error("counter read returned wrong value");

	chk_pin_gated: assert property (
		timer_out_pin == (s.level && s.oe))
		else $error("output pin not gated by enable");

	chk_oneshot_idle: assert property (
		(os_mode && !s.os_armed && !trig) |=> $stable(s.level))
		else $error("idle one-shot changed output");

	chk_edge_none: assert property (
		(s.prm[`TPM_PR_PRI_LO +: 2] == `TPM_EDGE_NONE) |=> !pe.valid)
		else $error("edge seen with edge select none");

	chk_ovf_hold: assert property (
		(s.ovf && !(wr && paddr == `TPM_OFS_MODE)) |=> s.ovf)
		else $error("overflow flag lost without a write");

	chk_ppg_event: assert property (
		(s.mode == TPM_MATCH_CLR && tick && !per_cap && s.cnt == s.per) |=> period_irq)
		else $error("period match raised no event");

	chk_unmapped_err: assert property (
		(psel && !penable && !mapped(paddr)) ##1 (psel && penable) |-> pslverr)
		else $error("unmapped access gave no error");

	chk_ready_high: assert property (
		(psel && penable) |-> pready)
		else $error("access phase without ready");

	cov_ppg_cycle: cover property (s.mode == TPM_MATCH_CLR && pm ##[1:200] wm);
	cov_edge_clear: cover property (edge_clr ##1 s.cnt == 16'h0);
	cov_oneshot: cover property (trig ##[1:300] (s.os_armed && pm));
	cov_capture: cover property (wid_cap && pe.valid ##[1:300] (per_cap && per_src));
	cov_overflow: cover property ($rose(s.ovf));
endmodule // tpm_timer
`default_nettype wire

// ---- tpm_pins.sv ----
`default_nettype none
module tpm_pins (
	input  wire logic pclk,
	output logic      primary_in_pin,
	output logic      secondary_in_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	// Pins hold still unless a scenario asks for an edge
	initial begin
		primary_in_pin = 1'b0;
		secondary_in_pin = 1'b0;
	end
	// Gap lets the current pulse finish before any new edge
	task automatic tog(input bit sec, input int gap);
		@(posedge pclk);
		if (sec) secondary_in_pin <= ~secondary_in_pin;
		else primary_in_pin <= ~primary_in_pin;
		repeat (gap) @(posedge pclk);
	endtask
endmodule // tpm_pins
`default_nettype wire

// ---- tb.sv ----
`default_nettype none
`include "tpm_defines.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        pri, sec, tout, pirq, wirq;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, p, w, r;
	logic [32:0] q[$];
	logic [32:0] e;
	logic [2:0]  s;
	int          n_mismatch = 0, num_checks = 0, n, h, l;
	assign s = {tout, wirq, pirq};
	tpm_timer #(.DIV_W(2)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .primary_in_pin(pri),
		.secondary_in_pin(sec), .timer_out_pin(tout), .period_irq(pirq), .width_irq(wirq));
	tpm_pins u_pins (.pclk(pclk), .primary_in_pin(pri), .secondary_in_pin(sec));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic give_verdict;
		$display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] v);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= wr;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 16) begin
			n_mismatch++;
			give_verdict();
		end
		v = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [7:0] a, input logic [32:0] x);
		q.push_back(x);
		xfer(1'b0, a, 32'h0, r);
	endtask
	task automatic till(input int k, input logic v, output int c);
		c = 0;
		do begin
			// Settled values, away from the launching edge
			@(negedge pclk);
			c++;
		end while (s[k] !== v && c < 3000);
		if (c == 3000) begin
			n_mismatch++;
			give_verdict();
		end
	endtask
	task automatic quiet(input int k, output int c);
		c = 0;
		repeat (200) begin
			@(posedge pclk);
			if (s[k] !== 1'b0) c++;
		end
	endtask
	// Second process: compares each read made while a note waits against the oldest note
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite && q.size() > 0) begin
			e = q.pop_front();
			`CHK({pslverr, prdata}, e)
		end
	end
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		void'($urandom(95894));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rd(`TPM_OFS_MODE, 33'h0);
		rd(`TPM_OFS_COUNT, 33'h0);
		rd(8'h1C, 33'h1_0000_0000);
		$display("reset test done");
		wr(`TPM_OFS_PERIOD, 32'h9);
		wr(`TPM_OFS_WIDTH, 32'h3);
		wr(`TPM_OFS_OUTCTRL, 32'h13);
		wr(`TPM_OFS_MODE, 32'h0C);
		till(0, 1'b1, n);
		till(0, 1'b1, n);
		`CHK(n, 10)
		till(1, 1'b1, n);
		`CHK(n, 4)
		till(2, 1'b0, n);
		till(2, 1'b1, n);
		`CHK(n, 4)
		till(2, 1'b0, n);
		`CHK(n, 6)
		$display("pulse generation test done");
		wr(`TPM_OFS_MODE, 32'h0);
		wr(`TPM_OFS_PERIOD, 32'h14);
		wr(`TPM_OFS_WIDTH, 32'h19);
		wr(`TPM_OFS_PRESCALE, 32'h10);
		wr(`TPM_OFS_OUTCTRL, 32'h21);
		wr(`TPM_OFS_MODE, 32'h04);
		wr(`TPM_OFS_OUTCTRL, 32'h61);
		till(0, 1'b1, n);
		till(1, 1'b1, n);
		`CHK(n, 5)
		u_pins.tog(0, 0);
		till(2, 1'b1, n);
		till(2, 1'b0, n);
		`CHK(n, 5)
		quiet(2, n);
		`CHK(n, 0)
		wr(`TPM_OFS_OUTCTRL, 32'h41);
		quiet(2, n);
		`CHK(n, 0)
		$display("one-shot test done");
		h = 20 + $urandom % 30;
		l = 20 + $urandom % 30;
		wr(`TPM_OFS_MODE, 32'h0);
		wr(`TPM_OFS_CAPCTRL, 32'h7);
		wr(`TPM_OFS_MODE, 32'h08);
		u_pins.tog(0, l);
		u_pins.tog(0, h);
		u_pins.tog(0, l);
		u_pins.tog(0, 8);
		xfer(1'b0, `TPM_OFS_PERIOD, 32'h0, p);
		xfer(1'b0, `TPM_OFS_WIDTH, 32'h0, w);
		`CHK(w - p, 32'(l + 1))
		`CHK(p == h || p == h - 1, 1'b1)
		wr(`TPM_OFS_MODE, 32'h0);
		wr(`TPM_OFS_MODE, 32'h04);
		u_pins.tog(0, l);
		u_pins.tog(0, 8);
		xfer(1'b0, `TPM_OFS_PERIOD, 32'h0, p);
		xfer(1'b0, `TPM_OFS_WIDTH, 32'h0, w);
		`CHK(w - p, 32'(l + 1))
		wr(`TPM_OFS_CAPCTRL, 32'h5);
		wr(`TPM_OFS_PRESCALE, 32'hF0);
		u_pins.tog(0, h);
		u_pins.tog(1, 8);
		xfer(1'b0, `TPM_OFS_PERIOD, 32'h0, p);
		xfer(1'b0, `TPM_OFS_WIDTH, 32'h0, w);
		`CHK(p - w, 32'(h + 1))
		$display("capture test done");
		xfer(1'b0, `TPM_OFS_COUNT, 32'h0, p);
		xfer(1'b0, `TPM_OFS_COUNT, 32'h0, w);
		`CHK(w - p, 32'h3)
		repeat (65536) @(posedge pclk);
		rd(`TPM_OFS_MODE, 33'h05);
		wr(`TPM_OFS_MODE, 32'h04);
		rd(`TPM_OFS_MODE, 33'h04);
		$display("counter test done");
		give_verdict();
	end
endmodule // tb
`default_nettype wire
